// File: asq_consts.vh
// Purpose: shared constants of the converter sequencer
// Assumes: 16-bit register port, 125 MHz clock
// Notes:   definitions only
`ifndef ASQ_CONSTS_VH
`define ASQ_CONSTS_VH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define ASQ_A_DIS        16'hebd2
`define ASQ_A_DIS_SET    16'hebd4
`define ASQ_A_DIS_CLR    16'hebd6
`define ASQ_A_CTRL       16'hffa0
`define ASQ_A_RESULT     16'hffa2
`define ASQ_A_INJ        16'hffa4
`define ASQ_A_PA_DIS     16'hffa6
`define ASQ_A_FLAGS      16'hffa8
`define ASQ_A_MISC       16'heb50
`define ASQ_A_ACC_EN     16'heb60

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ASQ_CH_HI        4
`define ASQ_CH_LO        0
`define ASQ_MODE_HI      6
`define ASQ_MODE_LO      5
`define ASQ_RUN          7
`define ASQ_BUSY         8
`define ASQ_WFR          9
`define ASQ_INJ_REQ      10
`define ASQ_PROTECT      11
`define ASQ_STC_HI       13
`define ASQ_STC_LO       12
`define ASQ_CTC_HI       15
`define ASQ_CTC_LO       14
`define ASQ_RES_CH_HI    14
`define ASQ_RES_CH_LO    10
`define ASQ_RES_HI       9
`define ASQ_RES_LO       0
`define ASQ_F_DONE       0
`define ASQ_F_OVR        1
`define ASQ_F_INJ        2
`define ASQ_MISC_MUX     0
`define ASQ_EN_MISC      0
`define ASQ_EN_DIS       1

// ----------------------------------------------------------------
// modes and reset values
// ----------------------------------------------------------------
`define ASQ_M_SINGLE     2'h0
`define ASQ_M_CONT       2'h1
`define ASQ_M_SCAN       2'h2
`define ASQ_M_SCAN_CONT  2'h3
`define ASQ_CTC_X2       2'h3
`define ASQ_CTC_X4       2'h2
`define ASQ_RST16        16'h0000
`define ASQ_CAL_RESULT   15'h0000

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define ASQ_CLK_MHZ      125
`define ASQ_CAL_CYCLES   16'd40629
`define ASQ_SAMP0_NS     940
`define ASQ_SAMP1_NS     1090
`define ASQ_SAMP2_NS     1560
`define ASQ_SAMP3_NS     3130
`define ASQ_COMP_NS      1880
`define ASQ_NS2CYC(t)    (((t) * `ASQ_CLK_MHZ + 999) / 1000)
`define ASQ_FIFO_DEPTH   16
`define ASQ_FIFO_AW      4

`endif

// File: asq_fifo.v
// Purpose: result buffer between converter and result register
// Assumes: single clock, DEPTH a power of two equal to 2**AW
// Notes:   valid/ready on both sides
`timescale 1ns/1ps
module asq_fifo #(
  parameter WIDTH = 15,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // clock and reset
  input  wire             clk,
  input  wire             srst,
  // fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  localparam [31:0] DEPTH_W = DEPTH;

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            push;
  wire            pop;

  assign in_ready  = (count != DEPTH_W[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push & ~pop) begin
        count <= count + {{AW{1'b0}}, 1'b1};
      end else if (pop & ~push) begin
        count <= count - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule // asq_fifo

// File: asq_timer.v
// Purpose: sample and comparison phase timing of one conversion
// Assumes: 125 MHz clock
// Notes:   done is a one-cycle pulse
`timescale 1ns/1ps
`include "asq_consts.vh"
module asq_timer (
  // clock and reset
  input  wire       clk,
  input  wire       srst,
  // control
  input  wire       start,
  input  wire [1:0] stc,
  input  wire [1:0] ctc,
  // phases
  output reg        sampling,
  output reg        comparing,
  output reg        done
);
  localparam [31:0] S0 = `ASQ_NS2CYC(`ASQ_SAMP0_NS);
  localparam [31:0] S1 = `ASQ_NS2CYC(`ASQ_SAMP1_NS);
  localparam [31:0] S2 = `ASQ_NS2CYC(`ASQ_SAMP2_NS);
  localparam [31:0] S3 = `ASQ_NS2CYC(`ASQ_SAMP3_NS);
  localparam [31:0] C0 = `ASQ_NS2CYC(`ASQ_COMP_NS);

  reg  [11:0] cnt;
  reg  [11:0] samp_base;
  wire [1:0]  shift;
  wire [11:0] samp_len;
  wire [11:0] comp_len;

  always @* begin
    case (stc)
      2'h0:    samp_base = S0[11:0];
      2'h1:    samp_base = S1[11:0];
      2'h2:    samp_base = S2[11:0];
      default: samp_base = S3[11:0];
    endcase
  end

  assign shift    = (ctc == `ASQ_CTC_X2) ? 2'h1 : (ctc == `ASQ_CTC_X4) ? 2'h2 : 2'h0;
  assign samp_len = samp_base << shift;
  assign comp_len = C0[11:0] << shift;

  always @(posedge clk) begin
    if (srst) begin
      sampling  <= 1'b0;
      comparing <= 1'b0;
      done      <= 1'b0;
      cnt       <= 12'h000;
    end else begin
      done <= 1'b0;
      if (start) begin
        sampling <= 1'b1;
        cnt      <= samp_len - 12'h001;
      end else if (cnt != 12'h000) begin
        cnt <= cnt - 12'h001;
      end else if (sampling) begin
        sampling  <= 1'b0;
        comparing <= 1'b1;
        cnt       <= comp_len - 12'h001;
      end else if (comparing) begin
        comparing <= 1'b0;
        done      <= 1'b1;
      end
    end
  end
endmodule // asq_timer

// File: asq_top.v
// Purpose: sequencer, result handling and line disable registers of the converter
// Assumes: register port on the CPU clock; analog code input settles before done
// Notes:   analog code and injection trigger are synchronised
`timescale 1ns/1ps
`include "asq_consts.vh"
// Function
// - disable bit 0 enables a second-port line's digital buffer, 1 disables it
// - writing ones to the set register sets those disable bits only
// - writing ones to the clear register clears those disable bits only
// - signalling mode raises overrun when a result completes over an unread one
// - protection mode holds the next conversion until the result is read
// - single mode converts the selected channel once into the result register
// - continuous mode converts the selected channel over and over
// - scan single converts each selected channel once, each result stored
// - scan continuous sweeps the selected channels repeatedly
// - wait-for-read buffers a new result and pauses until the read
// - injection converts one channel between continuous ones into its own field
// - channels 0-15 from the first port, 16-31 from the second
// - mux select disables first-port channels and routes from the second port
// - misc and second-port disable registers reachable only after their access enables
// - self-calibration runs after every reset
// - sample-time code picks one of four increasing sample times
// - conversion-time code scales sampling and comparison: 00 x1, 11 x2, 10 x4
// - first-port lines need no setup; own disable register guards them
// - busy stays set during calibration; no conversion starts before its end
// - calibration end leaves done and overrun flags set
module asq_top #(
  parameter [15:0] CAL_CYCLES = `ASQ_CAL_CYCLES
) (
  // clock and reset
  input  wire        clk,
  input  wire        srst,
  // register port
  input  wire [15:0] bus_addr,
  input  wire [15:0] bus_wdata,
  input  wire        bus_wr,
  input  wire        bus_rd,
  output reg  [15:0] bus_rdata,
  // analog front end
  input  wire [9:0]  ana_code,
  output reg  [3:0]  ana_line,
  output wire        ana_from_port_b,
  output wire        ana_port_a_en,
  output wire        ana_sample,
  output wire        ana_compare,
  // injection trigger pin
  input  wire        inj_trig,
  // digital input buffer enables
  output wire [15:0] port_a_dig_en,
  output wire [15:0] port_b_dig_en,
  // status
  output wire        busy
);
  localparam [3:0] ST_CAL   = 4'h1;
  localparam [3:0] ST_IDLE  = 4'h2;
  localparam [3:0] ST_CONV  = 4'h4;
  localparam [3:0] ST_WRITE = 4'h8;
  localparam [15:0] CAL_LAST = CAL_CYCLES - 16'd1;

  reg  [3:0]  state;
  reg  [15:0] cal_cnt;
  reg  [15:0] dis_b;
  reg  [15:0] dis_a;
  reg  [4:0]  ctl_ch;
  reg  [1:0]  ctl_mode;
  reg         ctl_run;
  reg         ctl_wfr;
  reg         ctl_protect;
  reg  [1:0]  ctl_stc;
  reg  [1:0]  ctl_ctc;
  reg         mux_sel;
  reg  [1:0]  acc_en;
  reg  [14:0] result;
  reg         unread;
  reg  [9:0]  inj_res;
  reg  [4:0]  inj_ch;
  reg         flag_done;
  reg         flag_ovr;
  reg         flag_inj;
  reg         inj_pend;
  reg         sweep_on;
  reg  [4:0]  chan_cur;
  reg         is_inj;
  reg         line_b;
  reg  [9:0]  conv_code;
  reg  [9:0]  code_s1;
  reg  [9:0]  code_s2;
  reg         trig_s1;
  reg         trig_s2;
  reg         trig_s3;
  reg  [15:0] next_rdata;

  wire        tmr_start;
  wire        tmr_done;
  wire        fifo_in_ready;
  wire        fifo_out_valid;
  wire        fifo_pull;
  wire [14:0] fifo_out_data;
  wire        fifo_push;
  wire        continuous;
  wire        start_ok;
  wire        in_idle;
  wire        rd_result;
  wire        wr_ctrl;
  wire        wr_flags;
  wire        ovr_event;
  wire        inj_set;
  wire        en_misc;
  wire        en_dis;
  wire [4:0]  conv_ch;
  wire        route_b;

  function hit;
    input [15:0] addr;
    input [15:0] target;
    begin
      hit = (addr == target);
    end
  endfunction

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    code_s1 <= ana_code;
    code_s2 <= code_s1;
    trig_s1 <= inj_trig;
    trig_s2 <= trig_s1;
    trig_s3 <= trig_s2;
  end

  // ----------------------------------------------------------------
  // decode and sequencing terms
  // ----------------------------------------------------------------
  assign en_misc    = acc_en[`ASQ_EN_MISC];
  assign en_dis     = acc_en[`ASQ_EN_DIS];
  assign rd_result  = bus_rd & hit(bus_addr, `ASQ_A_RESULT);
  assign wr_ctrl    = bus_wr & hit(bus_addr, `ASQ_A_CTRL);
  assign wr_flags   = bus_wr & hit(bus_addr, `ASQ_A_FLAGS);
  assign continuous = (ctl_mode == `ASQ_M_CONT) | (ctl_mode == `ASQ_M_SCAN_CONT);
  assign in_idle    = (state == ST_IDLE);
  assign busy       = ~in_idle;
  assign start_ok   = ctl_protect ? (~fifo_out_valid & ~unread) :
                      ctl_wfr     ? ~fifo_out_valid : 1'b1;
  assign tmr_start  = in_idle & ctl_run & sweep_on & start_ok;
  assign conv_ch    = (inj_pend & continuous) ? inj_ch : chan_cur;
  assign fifo_push  = (state == ST_WRITE) & ~is_inj;
  assign fifo_pull  = fifo_out_valid & (~unread | (~ctl_wfr & ~ctl_protect));
  assign ovr_event  = fifo_pull & unread & ~rd_result;
  assign inj_set    = (trig_s2 & ~trig_s3) | (wr_ctrl & bus_wdata[`ASQ_INJ_REQ]);

  // ----------------------------------------------------------------
  // analog routing and digital enables
  // ----------------------------------------------------------------
  assign route_b         = mux_sel | line_b;
  assign ana_from_port_b = route_b;
  assign ana_port_a_en   = ~mux_sel;
  assign port_b_dig_en   = ~dis_b;
  assign port_a_dig_en   = ~dis_a;

  // ----------------------------------------------------------------
  // conversion timing and result buffer
  // ----------------------------------------------------------------
  asq_timer u_timer (
    .clk       (clk),
    .srst      (srst),
    .start     (tmr_start),
    .stc       (ctl_stc),
    .ctc       (ctl_ctc),
    .sampling  (ana_sample),
    .comparing (ana_compare),
    .done      (tmr_done)
  );

  asq_fifo #(
    .WIDTH (15),
    .DEPTH (`ASQ_FIFO_DEPTH),
    .AW    (`ASQ_FIFO_AW)
  ) u_fifo (
    .clk       (clk),
    .srst      (srst),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .in_data   ({chan_cur, conv_code}),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pull),
    .out_data  (fifo_out_data)
  );

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      state     <= ST_CAL;
      cal_cnt   <= `ASQ_RST16;
      sweep_on  <= 1'b0;
      chan_cur  <= 5'h00;
      is_inj    <= 1'b0;
      line_b    <= 1'b0;
      conv_code <= 10'h000;
      ana_line  <= 4'h0;
      inj_pend  <= 1'b0;
    end else begin
      inj_pend <= inj_set | (inj_pend & ~(tmr_start & continuous));
      case (state)
        ST_CAL: begin
          cal_cnt <= cal_cnt + 16'd1;
          if (cal_cnt == CAL_LAST) begin
            state <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (ctl_run & ~sweep_on) begin
            sweep_on <= 1'b1;
            chan_cur <= ctl_ch;
          end else if (tmr_start) begin
            is_inj   <= inj_pend & continuous;
            ana_line <= conv_ch[3:0];
            line_b   <= conv_ch[4];
            state    <= ST_CONV;
          end else if (~ctl_run) begin
            sweep_on <= 1'b0;
          end
        end
        ST_CONV: begin
          if (tmr_done) begin
            conv_code <= code_s2;
            state     <= ST_WRITE;
          end
        end
        ST_WRITE: begin
          if (is_inj) begin
            state <= ST_IDLE;
          end else if (fifo_in_ready) begin
            state <= ST_IDLE;
            case (ctl_mode)
              `ASQ_M_SINGLE: sweep_on <= 1'b0;
              `ASQ_M_CONT: sweep_on <= 1'b1;
              default: begin
                if (chan_cur == 5'h00) begin
                  sweep_on <= 1'b0;
                end else begin
                  chan_cur <= chan_cur - 5'h01;
                end
              end
            endcase
          end
        end
        default: state <= ST_CAL;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers written by software
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      dis_b       <= `ASQ_RST16;
      dis_a       <= `ASQ_RST16;
      ctl_ch      <= 5'h00;
      ctl_mode    <= `ASQ_M_SINGLE;
      ctl_run     <= 1'b0;
      ctl_wfr     <= 1'b0;
      ctl_protect <= 1'b0;
      ctl_stc     <= 2'h0;
      ctl_ctc     <= 2'h0;
      mux_sel     <= 1'b0;
      acc_en      <= 2'h0;
      inj_ch      <= 5'h00;
    end else begin
      if ((state == ST_WRITE) & ~is_inj & fifo_in_ready & (chan_cur == 5'h00)
          & (ctl_mode == `ASQ_M_SCAN)) begin
        ctl_run <= 1'b0;
      end
      if ((state == ST_WRITE) & ~is_inj & fifo_in_ready & (ctl_mode == `ASQ_M_SINGLE)) begin
        ctl_run <= 1'b0;
      end
      if (wr_ctrl) begin
        ctl_ch      <= bus_wdata[`ASQ_CH_HI:`ASQ_CH_LO];
        ctl_mode    <= bus_wdata[`ASQ_MODE_HI:`ASQ_MODE_LO];
        ctl_run     <= bus_wdata[`ASQ_RUN];
        ctl_wfr     <= bus_wdata[`ASQ_WFR];
        ctl_protect <= bus_wdata[`ASQ_PROTECT];
        ctl_stc     <= bus_wdata[`ASQ_STC_HI:`ASQ_STC_LO];
        ctl_ctc     <= bus_wdata[`ASQ_CTC_HI:`ASQ_CTC_LO];
      end
      if (bus_wr & hit(bus_addr, `ASQ_A_INJ)) begin
        inj_ch <= bus_wdata[`ASQ_RES_CH_HI:`ASQ_RES_CH_LO];
      end
      if (bus_wr & hit(bus_addr, `ASQ_A_PA_DIS)) begin
        dis_a <= bus_wdata;
      end
      if (bus_wr & hit(bus_addr, `ASQ_A_ACC_EN)) begin
        acc_en <= {bus_wdata[`ASQ_EN_DIS], bus_wdata[`ASQ_EN_MISC]};
      end
      if (bus_wr & en_misc & hit(bus_addr, `ASQ_A_MISC)) begin
        mux_sel <= bus_wdata[`ASQ_MISC_MUX];
      end
      if (bus_wr & en_dis & hit(bus_addr, `ASQ_A_DIS)) begin
        dis_b <= bus_wdata;
      end else if (bus_wr & en_dis & hit(bus_addr, `ASQ_A_DIS_SET)) begin
        dis_b <= dis_b | bus_wdata;
      end else if (bus_wr & en_dis & hit(bus_addr, `ASQ_A_DIS_CLR)) begin
        dis_b <= dis_b & ~bus_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // results and flags
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      result    <= `ASQ_CAL_RESULT;
      unread    <= 1'b0;
      inj_res   <= 10'h000;
      flag_done <= 1'b0;
      flag_ovr  <= 1'b0;
      flag_inj  <= 1'b0;
    end else begin
      if (wr_flags) begin
        flag_done <= flag_done & ~bus_wdata[`ASQ_F_DONE];
        flag_ovr  <= flag_ovr & ~bus_wdata[`ASQ_F_OVR];
        flag_inj  <= flag_inj & ~bus_wdata[`ASQ_F_INJ];
      end
      if (rd_result) begin
        unread <= 1'b0;
      end
      if ((state == ST_CAL) & (cal_cnt == CAL_LAST)) begin
        result    <= `ASQ_CAL_RESULT;
        unread    <= 1'b1;
        flag_done <= 1'b1;
        flag_ovr  <= 1'b1;
      end
      if (fifo_pull) begin
        result    <= fifo_out_data;
        unread    <= 1'b1;
        flag_done <= 1'b1;
      end
      if (ovr_event) begin
        flag_ovr <= 1'b1;
      end
      if ((state == ST_WRITE) & is_inj) begin
        inj_res  <= conv_code;
        flag_inj <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always @* begin
    next_rdata = `ASQ_RST16;
    if (hit(bus_addr, `ASQ_A_CTRL)) begin
      next_rdata = {ctl_ctc, ctl_stc, ctl_protect, inj_pend, ctl_wfr, busy,
                    ctl_run, ctl_mode, ctl_ch};
    end else if (hit(bus_addr, `ASQ_A_RESULT)) begin
      next_rdata = {1'b0, result};
    end else if (hit(bus_addr, `ASQ_A_INJ)) begin
      next_rdata = {1'b0, inj_ch, inj_res};
    end else if (hit(bus_addr, `ASQ_A_PA_DIS)) begin
      next_rdata = dis_a;
    end else if (hit(bus_addr, `ASQ_A_FLAGS)) begin
      next_rdata = {13'h0000, flag_inj, flag_ovr, flag_done};
    end else if (hit(bus_addr, `ASQ_A_ACC_EN)) begin
      next_rdata = {14'h0000, acc_en};
    end else if (hit(bus_addr, `ASQ_A_MISC) & en_misc) begin
      next_rdata = {15'h0000, mux_sel};
    end else if (hit(bus_addr, `ASQ_A_DIS) & en_dis) begin
      next_rdata = dis_b;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      bus_rdata <= `ASQ_RST16;
    end else if (bus_rd) begin
      bus_rdata <= next_rdata;
    end
  end
endmodule // asq_top

// File: asq_top_chk.sv
// Purpose: port assertions of asq_top
// Assumes: disable regs unlock by 0xeb60 bit1
// Notes:   bind at file foot
`timescale 1ns/1ps
module asq_top_chk #(
  parameter [15:0] CAL_CYCLES = 16'd16
) (
  // clock and reset
  input wire        clk,
  input wire        srst,
  // register port
  input wire [15:0] bus_addr,
  input wire [15:0] bus_wdata,
  input wire        bus_wr,
  input wire        bus_rd,
  input wire [15:0] bus_rdata,
  // converter and lines
  input wire        ana_from_port_b,
  input wire        ana_port_a_en,
  input wire        ana_sample,
  input wire        ana_compare,
  input wire [15:0] port_a_dig_en,
  input wire [15:0] port_b_dig_en,
  input wire        busy
);
  // --------
  // unlock shadow
  // --------
  reg  unl;
  wire w_set = bus_wr && unl && bus_addr == 16'hebd4;
  wire w_clr = bus_wr && unl && bus_addr == 16'hebd6;
  always @(posedge clk) begin
    if (srst)
      unl <= 1'b0;
    else if (bus_wr && bus_addr == 16'heb60)
      unl <= bus_wdata[1];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // --------
  // assertions
  // --------
  mux_route_a: assert property (ana_port_a_en == !ana_from_port_b)
    else $error("port enables disagree");
  cal_busy_a: assert property ($fell(srst) |-> (busy && !ana_sample)[*8])
    else $error("calibration not busy");
  conv_busy_a: assert property ((ana_sample || ana_compare) |-> busy)
    else $error("phase without busy");
  set_bits_a: assert property (w_set |=> (port_b_dig_en & $past(bus_wdata)) == 16'h0000)
    else $error("set bits missed");
  set_keep_a: assert property (w_set |=>
    ((port_b_dig_en ^ $past(port_b_dig_en)) & ~$past(bus_wdata)) == 16'h0000)
    else $error("set touched zero bits");
  clr_bits_a: assert property (w_clr |=> (~port_b_dig_en & $past(bus_wdata)) == 16'h0000)
    else $error("clear bits missed");
  lock_wr_a: assert property (bus_wr && !unl && bus_addr[15:4] == 12'hebd |=>
    $stable(port_b_dig_en)) else $error("locked write took effect");
  dis_read_a: assert property (bus_rd && bus_addr == 16'hebd2 |=>
    bus_rdata == ($past(unl) ? ~$past(port_b_dig_en) : 16'h0000))
    else $error("disable readback wrong");
  pa_dis_a: assert property (bus_wr && bus_addr == 16'hffa6 |=>
    port_a_dig_en == ~$past(bus_wdata)) else $error("first port enables wrong");
endmodule // asq_top_chk

bind asq_top asq_top_chk #(.CAL_CYCLES(CAL_CYCLES)) u_chk (.clk, .srst, .bus_addr,
  .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .ana_from_port_b, .ana_port_a_en,
  .ana_sample, .ana_compare, .port_a_dig_en, .port_b_dig_en, .busy);

// File: asq_ana_model.sv
// Purpose: analog pins seen by the converter
// Assumes: code settles with the line select
// Notes:   code names the routed port and line
`timescale 1ns/1ps
module asq_ana_model (
  // line select
  input wire [3:0]  ana_line,
  input wire        ana_from_port_b,
  // pins
  output wire [9:0] ana_code,
  output wire       inj_trig
);
  assign ana_code = {ana_from_port_b, ana_line, 5'h15};
  assign inj_trig = 1'b0;
endmodule // asq_ana_model

// File: adc_sequencer_input_disable_tb.sv
// Purpose: register level test of asq_top
// Assumes: calibration shortened to 16 cycles
// Notes:   inputs change at falling edge
`timescale 1ns/1ps
module adc_sequencer_input_disable_tb;
  reg         clk;
  reg         srst;
  reg  [15:0] bus_addr;
  reg  [15:0] bus_wdata;
  reg         bus_wr;
  reg         bus_rd;
  wire [15:0] bus_rdata;
  wire [9:0]  ana_code;
  wire [3:0]  ana_line;
  wire        ana_from_port_b;
  wire        ana_port_a_en;
  wire        ana_sample;
  wire        ana_compare;
  wire        inj_trig;
  wire [15:0] port_a_dig_en;
  wire [15:0] port_b_dig_en;
  wire        busy;
  reg  [15:0] rv;
  integer     err_count;
  integer     total_checks;
  integer     n;

  asq_top #(.CAL_CYCLES(16'd16)) uut (.clk(clk), .srst(srst), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .ana_code(ana_code), .ana_line(ana_line), .ana_from_port_b(ana_from_port_b),
    .ana_port_a_en(ana_port_a_en), .ana_sample(ana_sample), .ana_compare(ana_compare),
    .inj_trig(inj_trig), .port_a_dig_en(port_a_dig_en), .port_b_dig_en(port_b_dig_en),
    .busy(busy));
  asq_ana_model u_ana (.ana_line(ana_line), .ana_from_port_b(ana_from_port_b),
    .ana_code(ana_code), .inj_trig(inj_trig));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // --------
  // tasks
  // --------
  function [15:0] er(input [4:0] c);
    er = {1'b0, c, 1'b1, c[3:0], 5'h15};
  endfunction
  task chk(input [63:0] what, input [15:0] seen, input [15:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("MISMATCH %0s exp %h seen %h", what, exp, seen);
      end
    end
  endtask
  task wr(input [15:0] a, input [15:0] d);
    begin
      bus_addr = a;
      bus_wdata = d;
      bus_wr = 1'b1;
      @(negedge clk);
      bus_wr = 1'b0;
      @(negedge clk);
    end
  endtask
  task rd(input [15:0] a, output [15:0] d);
    begin
      bus_addr = a;
      bus_rd = 1'b1;
      @(negedge clk);
      bus_rd = 1'b0;
      @(negedge clk);
      d = bus_rdata;
    end
  endtask
  task wait_done;
    begin
      n = 0;
      rv = 16'h0000;
      while (rv[0] !== 1'b1 && n < 300) begin
        rd(16'hffa8, rv);
        n = n + 1;
      end
    end
  endtask
  task test_done;
    begin
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask

  // --------
  // sequence
  // --------
  initial begin
    #400000;
    err_count = err_count + 1;
    test_done;
  end
  initial begin
    err_count = 0;
    total_checks = 0;
    srst = 1'b1;
    bus_addr = 16'h0000;
    bus_wdata = 16'h0000;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    repeat (12) @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
    chk("calbusy", {15'h0, busy}, 16'h0001);
    n = 0;
    while (busy !== 1'b0 && n < 100) begin
      @(negedge clk);
      n = n + 1;
    end
    chk("callen", {15'h0, n >= 13 && n <= 17}, 16'h0001);
    rd(16'hffa8, rv);
    chk("calflag", rv, 16'h0003);
    wr(16'hebd4, 16'h00ff);
    rd(16'hebd2, rv);
    chk("locked", rv, 16'h0000);
    wr(16'heb60, 16'h0003);
    rd(16'hebd2, rv);
    chk("ignored", rv, 16'h0000);
    wr(16'hebd4, 16'h00a5);
    chk("set1", port_b_dig_en, 16'hff5a);
    wr(16'hebd4, 16'h0300);
    chk("set2", port_b_dig_en, 16'hfc5a);
    wr(16'hebd6, 16'h0021);
    rd(16'hebd2, rv);
    chk("clr", rv, 16'h0384);
    wr(16'hffa6, 16'h1234);
    chk("pa_en", port_a_dig_en, 16'hedcb);
    wr(16'heb50, 16'h0001);
    chk("mux", {14'h0, ana_from_port_b, ana_port_a_en}, 16'h0002);
    rd(16'hffa2, rv);
    wr(16'hffa8, 16'h0007);
    wr(16'hffa0, 16'h0085);
    wait_done;
    rd(16'hffa2, rv);
    chk("single", rv, er(5'd5));
    rd(16'hffa8, rv);
    chk("noovr", rv, 16'h0001);
    wr(16'hffa8, 16'h0007);
    wr(16'hffa0, 16'h00a3);
    wait_done;
    wr(16'hffa8, 16'h0001);
    wait_done;
    chk("ovr", rv, 16'h0003);
    wr(16'hffa0, 16'h0000);
    repeat (400) @(negedge clk);
    rd(16'hffa2, rv);
    chk("cont", rv, er(5'd3));
    wr(16'hffa8, 16'h0007);
    wr(16'hffa0, 16'h0082);
    wait_done;
    wr(16'hffa8, 16'h0007);
    wr(16'hffa0, 16'h0882);
    n = 0;
    repeat (40) begin
      @(negedge clk);
      n = n | busy;
    end
    chk("held", n[15:0], 16'h0000);
    rd(16'hffa2, rv);
    chk("prot1", rv, er(5'd2));
    wait_done;
    rd(16'hffa2, rv);
    chk("prot2", rv, er(5'd2));
    wr(16'hffa8, 16'h0007);
    wr(16'hffa0, 16'h00c1);
    repeat (800) @(negedge clk);
    rd(16'hffa0, rv);
    chk("scan_end", rv, 16'h0041);
    rd(16'hffa2, rv);
    chk("scan", rv, er(5'd0));
    rd(16'hffa8, rv);
    chk("scanovr", rv, 16'h0003);
    wr(16'hffa8, 16'h0007);
    wr(16'hffa4, 16'h1c00);
    wr(16'hffa0, 16'h06a4);
    repeat (1500) @(negedge clk);
    chk("paused", {15'h0, busy}, 16'h0000);
    rd(16'hffa8, rv);
    chk("wfr_flag", rv, 16'h0005);
    rd(16'hffa4, rv);
    chk("inj", rv, er(5'd7));
    rd(16'hffa2, rv);
    chk("wfr", rv, er(5'd4));
    wr(16'hffa0, 16'h0000);
    test_done;
  end
endmodule // adc_sequencer_input_disable_tb
